/* core/nvsc_params.svh */
// Constants for the nonvolatile SRAM host controller: timings, command addresses.
// Assumes a 40 MHz system clock; included by nvsc_cycle, nvsc_host and the pin checker, not by the package.
`ifndef NVSC_PARAMS_SVH
`define NVSC_PARAMS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define NVSC_CLK_MHZ          40
`define NVSC_CLK_PERIOD_NS    25

// ----------------------------------------------------------------
// Bus timing in nanoseconds, and derived cycle counts (rounded up)
// ----------------------------------------------------------------
`define NVSC_ACCESS_NS        45
`define NVSC_ACCESS_CYC       ((`NVSC_ACCESS_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_WPULSE_NS        30
`define NVSC_WPULSE_CYC       ((`NVSC_WPULSE_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_RECOVER_NS       15
`define NVSC_RECOVER_CYC      ((`NVSC_RECOVER_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Long waits in microseconds, plus the store pin pulse in nanoseconds
// ----------------------------------------------------------------
`define NVSC_SOFT_CMD_PROCESSING_TIME_US 70
`define NVSC_HW_STORE_GRACE_TIME_US      70
`define NVSC_RECALL_DURATION_US          50
`define NVSC_STORE_DURATION_US           12500
`define NVSC_HSB_PULSE_NS                15
`define NVSC_HSB_PULSE_CYC ((`NVSC_HSB_PULSE_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Command sequence addresses (low 14 bits only are decoded)
// ----------------------------------------------------------------
`define NVSC_SEQ_A0           15'h0e38
`define NVSC_SEQ_A1           15'h31c7
`define NVSC_SEQ_A2           15'h03e0
`define NVSC_SEQ_A3           15'h3c1f
`define NVSC_SEQ_A4           15'h303f
`define NVSC_CMD_ASDIS        15'h03f8
`define NVSC_CMD_ASEN         15'h07f0
`define NVSC_CMD_STORE        15'h0fc0
`define NVSC_CMD_RECALL       15'h0c63

`endif

/* core/nvsc_pkg.sv */
// Types shared by the nonvolatile SRAM host controller and its pin sequencer.
// Assumes nvsc_params.svh supplies the numeric constants.
package nvsc_pkg;

	// ----------------------------------------------------------------
	// User request kinds
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		NVSC_OP_READ   = 3'h0,
		NVSC_OP_WRITE  = 3'h1,
		NVSC_OP_STORE  = 3'h2,
		NVSC_OP_RECALL = 3'h3,
		NVSC_OP_AS_EN  = 3'h4,
		NVSC_OP_AS_DIS = 3'h5,
		NVSC_OP_HWST   = 3'h6
	} nvsc_op_t;

	// User request carrier
	typedef struct packed {
		nvsc_op_t    op;
		logic [14:0] addr;
		logic [7:0]  wdata;
	} nvsc_req_t;

	// Single pin cycle handed to the sequencer
	typedef struct packed {
		logic        wr;
		logic        keep_g;
		logic [14:0] addr;
		logic [7:0]  wdata;
	} nvsc_cyc_t;

	// Memory pins driven by the host
	typedef struct packed {
		logic        e_n;
		logic        w_n;
		logic        g_n;
		logic [14:0] addr;
	} nvsc_pins_t;

endpackage : nvsc_pkg

/* core/nvsc_cycle.sv */
// One asynchronous SRAM pin cycle (read or write) timed in system clocks.
// Assumes the caller holds start only while ready is high.
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_params.svh"

module nvsc_cycle
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Request
	input  wire logic             start,
	input  wire nvsc_pkg::nvsc_cyc_t cyc,
	output logic                  ready,
	output logic                  done,
	output logic [7:0]            rdata,
	// Pins
	output nvsc_pkg::nvsc_pins_t  pins,
	output logic [7:0]            dq_o,
	output logic                  dq_oe,
	input  wire logic [7:0]       dq_i_sync
);
	import nvsc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		NVSC_C_IDLE = 2'b00,
		NVSC_C_ACT  = 2'b01,
		NVSC_C_REC  = 2'b10
	} nvsc_cst_t;

	nvsc_cst_t   st_r;          // Cycle phase
	logic [3:0]  cnt_r;         // Phase timer
	logic        wr_r;          // Current cycle is a write

	localparam logic [3:0] ACT_RD = 4'(`NVSC_ACCESS_CYC + 2);  // Extra two for input sync
	localparam logic [3:0] ACT_WR = 4'(`NVSC_WPULSE_CYC);
	localparam logic [3:0] REC    = 4'(`NVSC_RECOVER_CYC);

	assign ready = (st_r == NVSC_C_IDLE);

	// ----------------------------------------------------------------
	// Phase sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		done <= 1'b0;
		if (reset)
		begin
			st_r  <= NVSC_C_IDLE;
			cnt_r <= 4'h0;
			wr_r  <= 1'b0;
			pins  <= '{e_n: 1'b1, w_n: 1'b1, g_n: 1'b1, addr: 15'h0000};
			dq_o  <= 8'h00;
			dq_oe <= 1'b0;
			rdata <= 8'h00;
		end
		else
		begin
			case (st_r)
				NVSC_C_IDLE:
				begin
					if (start)
					begin
						// Address set and E falls on the same edge: each read is E controlled RL1
						pins.addr <= cyc.addr;
						pins.e_n  <= 1'b0;
						pins.w_n  <= ~cyc.wr;                 // RL3
						pins.g_n  <= cyc.wr | cyc.keep_g;    // RL18
						dq_o      <= cyc.wdata;
						dq_oe     <= cyc.wr;
						wr_r      <= cyc.wr;
						cnt_r     <= cyc.wr ? ACT_WR : ACT_RD;
						st_r      <= NVSC_C_ACT;
					end
				end
				NVSC_C_ACT:
				begin
					if (cnt_r > 4'h1)
						cnt_r <= cnt_r - 4'h1;
					else
					begin
						// Address stays until E rises; data sampled at the end RL16
						if (!wr_r)
							rdata <= dq_i_sync;
						pins.e_n <= 1'b1;
						pins.w_n <= 1'b1;
						pins.g_n <= 1'b1;
						cnt_r    <= REC;
						st_r     <= NVSC_C_REC;
					end
				end
				NVSC_C_REC:
				begin
					// Data held one phase past the write end, then released
					dq_oe <= 1'b0;
					if (cnt_r > 4'h1)
						cnt_r <= cnt_r - 4'h1;
					else
					begin
						done <= 1'b1;
						st_r <= NVSC_C_IDLE;
					end
				end
				default:
					st_r <= NVSC_C_IDLE;
			endcase
		end
	end

endmodule : nvsc_cycle
`default_nettype wire

/* core/nvsc_host.sv */
// Host controller for a 32K x 8 SRAM with nonvolatile shadow copy.
// Assumes the memory is wired directly to the pins; dq and busy are async.
//
// Notes on behaviour
// RL1: Command sequence advances on E-controlled read falls.
// RL2: Six command reads issued consecutively, exact order.
// RL3: Write enable held high through all six.
// RL4: Five prefix reads return ordinary stored data.
// RL5: Sixth read 0x03F8/0x07F0 toggles autosave.
// RL6: Sixth read 0x0FC0 starts store, data floats.
// RL7: Sixth read 0x0C63 starts recall.
// RL8: Decoder compares only low fourteen address bits.
// RL9: Command acted upon within 70 us.
// RL10: Device ignores inputs during store or recall.
// RL11: Hardware store: SRAM disabled within 70 us.
// RL12: Array blocked for whole store or recall.
// RL13: Read when E, G low, W, busy high.
// RL14: Read data follows address until control change.
// RL15: Write when E, W low, busy high.
// RL16: Address stable across whole write cycle.
// RL17: Data committed at rising end of write.
// RL18: Keep output enable high during writes.
// RL19: Device drivers off after write enable falls.
// RL20: Hardware store only after a write.
// RL21: Busy pin low while any store runs.
// RL22: Writes after busy falls are inhibited.
// RL23: Write held off until new enable fall.
// RL24: Chip enable high deselects device.
// RL25: Broken order or write resets detector.
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_params.svh"

module nvsc_host
#(
	parameter int CLK_MHZ   = `NVSC_CLK_MHZ,
	parameter int SS_US     = `NVSC_SOFT_CMD_PROCESSING_TIME_US,
	parameter int GRACE_US  = `NVSC_HW_STORE_GRACE_TIME_US,
	parameter int RECALL_US = `NVSC_RECALL_DURATION_US,
	parameter int STORE_US  = `NVSC_STORE_DURATION_US
)
(
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                reset,
	// User request
	input  wire logic                req_valid,
	input  wire nvsc_pkg::nvsc_req_t req,
	output logic                     req_ready,
	// User answer
	output logic                     rsp_valid,
	output logic [7:0]               rsp_rdata,
	output logic                     busy,
	// Memory pins
	output nvsc_pkg::nvsc_pins_t     mem_pins,
	output logic [7:0]               dq_o,
	output logic                     dq_oe,
	input  wire logic [7:0]          dq_i,
	// Store request / busy pin, open drain
	output logic                     hw_store_busy_n_o,
	output logic                     hw_store_busy_n_oe,
	input  wire logic                hw_store_busy_n_i
);
	import nvsc_pkg::*;

	// ----------------------------------------------------------------
	// Derived wait counts (cycles)
	// ----------------------------------------------------------------
	localparam int SS_CYC     = SS_US * CLK_MHZ;
	localparam int GRACE_CYC  = GRACE_US * CLK_MHZ;
	localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
	localparam int STORE_CYC  = STORE_US * CLK_MHZ;
	localparam int PULSE_CYC  = `NVSC_HSB_PULSE_CYC;

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		NVSC_IDLE  = 3'b000,
		NVSC_ISSUE = 3'b001,
		NVSC_WAIT  = 3'b010,
		NVSC_HOLD  = 3'b011,
		NVSC_PULSE = 3'b100,
		NVSC_BUSYW = 3'b101
	} nvsc_st_t;

	nvsc_st_t    st_r;              // Main sequence state
	nvsc_req_t   req_r;             // Latched request
	logic [2:0]  step_r;            // Command read index 0..5
	logic [31:0] tmr_r;             // Long wait timer
	logic        busy_seen_r;       // Busy pin observed low since the store wait began

	// ----------------------------------------------------------------
	// Input synchronisers: two flops before any use
	// ----------------------------------------------------------------
	logic [8:0]  sync1_r;           // First stage, read only by second
	logic [8:0]  sync2_r;           // Second stage

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			sync1_r <= 9'h1ff;
			sync2_r <= 9'h1ff;
		end
		else
		begin
			sync1_r <= {hw_store_busy_n_i, dq_i};
			sync2_r <= sync1_r;
		end
	end

	logic busy_pin_n;               // Synchronised store/busy level
	assign busy_pin_n = sync2_r[8];

	// ----------------------------------------------------------------
	// Command address table for the six reads
	// ----------------------------------------------------------------
	function automatic logic [14:0] seq_addr(input logic [2:0] i, input nvsc_op_t op);
		logic [14:0] a;
		a = 15'h0000;
		case (i)
			3'h0: a = `NVSC_SEQ_A0;
			3'h1: a = `NVSC_SEQ_A1;
			3'h2: a = `NVSC_SEQ_A2;
			3'h3: a = `NVSC_SEQ_A3;
			3'h4: a = `NVSC_SEQ_A4;
			default:
			begin
				case (op)
					NVSC_OP_STORE:  a = `NVSC_CMD_STORE;   // RL6
					NVSC_OP_RECALL: a = `NVSC_CMD_RECALL;  // RL7
					NVSC_OP_AS_DIS: a = `NVSC_CMD_ASDIS;   // RL5
					default:        a = `NVSC_CMD_ASEN;    // RL5
				endcase
			end
		endcase
		// Top bit left zero; only the low 14 bits are decoded RL8
		seq_addr = a & 15'h3fff;
	endfunction : seq_addr

	// ----------------------------------------------------------------
	// Pin cycle sequencer
	// ----------------------------------------------------------------
	logic      cyc_start;           // Launch one pin cycle
	logic      cyc_ready;           // Sequencer idle
	logic      cyc_done;            // Pin cycle finished
	logic [7:0] cyc_rdata;          // Sampled read data
	nvsc_cyc_t cyc;                 // Cycle descriptor
	logic      is_cmd;              // Request is a six-read command

	assign is_cmd = (req_r.op != NVSC_OP_READ) && (req_r.op != NVSC_OP_WRITE)
		&& (req_r.op != NVSC_OP_HWST);

	always_comb
	begin
		cyc.wr     = (req_r.op == NVSC_OP_WRITE);
		cyc.keep_g = 1'b0;
		cyc.addr   = is_cmd ? seq_addr(step_r, req_r.op) : req_r.addr;
		cyc.wdata  = req_r.wdata;
	end

	// Only issue while busy pin reads high, no access during a store RL22
	// Not in the done cycle: the sequencer is idle then, but the step is stale
	assign cyc_start = (st_r == NVSC_ISSUE) && cyc_ready && !cyc_done && busy_pin_n;

	nvsc_cycle u_cycle
	(
		.sys_clk   (sys_clk),
		.reset     (reset),
		.start     (cyc_start),
		.cyc       (cyc),
		.ready     (cyc_ready),
		.done      (cyc_done),
		.rdata     (cyc_rdata),
		.pins      (mem_pins),
		.dq_o      (dq_o),
		.dq_oe     (dq_oe),
		.dq_i_sync (sync2_r[7:0])
	);

	// ----------------------------------------------------------------
	// Handshake outputs
	// ----------------------------------------------------------------
	assign req_ready = (st_r == NVSC_IDLE);
	assign busy      = (st_r != NVSC_IDLE) || !busy_pin_n;  // RL21

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		rsp_valid <= 1'b0;
		if (reset)
		begin
			st_r               <= NVSC_IDLE;
			req_r              <= '0;
			step_r             <= 3'h0;
			tmr_r              <= 32'h0000_0000;
			busy_seen_r        <= 1'b0;
			rsp_rdata          <= 8'h00;
			hw_store_busy_n_oe <= 1'b0;
		end
		else
		begin
			case (st_r)
				NVSC_IDLE:
				begin
					if (req_valid)
					begin
						req_r  <= req;
						step_r <= 3'h0;
						st_r   <= (req.op == NVSC_OP_HWST) ? NVSC_PULSE : NVSC_ISSUE;
						tmr_r  <= 32'(PULSE_CYC);
						if (req.op == NVSC_OP_HWST)
							hw_store_busy_n_oe <= 1'b1;  // Pull the pin low RL11
					end
				end
				NVSC_ISSUE:
				begin
					// No other access is interleaved between command reads RL2
					if (cyc_done)
					begin
						rsp_rdata <= cyc_rdata;  // Prefix reads return stored data RL4
						if (is_cmd && step_r != 3'h5)
							step_r <= step_r + 3'h1;
						else if (is_cmd)
						begin
							// Give the device its processing time before any access RL9
							tmr_r       <= 32'(SS_CYC);
							busy_seen_r <= 1'b0;
							st_r        <= NVSC_WAIT;
						end
						else
						begin
							rsp_valid <= 1'b1;
							st_r      <= NVSC_IDLE;
						end
					end
				end
				NVSC_WAIT:
				begin
					// Store and recall lock the device out, so extend the wait RL10 RL12
					if (tmr_r != 32'h0000_0000)
						tmr_r <= tmr_r - 32'h0000_0001;
					else if (req_r.op == NVSC_OP_RECALL)
					begin
						tmr_r <= 32'(RECALL_CYC);
						st_r  <= NVSC_HOLD;
					end
					else if (req_r.op == NVSC_OP_STORE)
					begin
						tmr_r <= 32'(STORE_CYC);
						st_r  <= NVSC_BUSYW;
					end
					else
					begin
						rsp_valid <= 1'b1;
						st_r      <= NVSC_IDLE;
					end
				end
				NVSC_HOLD:
				begin
					if (tmr_r != 32'h0000_0000)
						tmr_r <= tmr_r - 32'h0000_0001;
					else
					begin
						rsp_valid <= 1'b1;
						st_r      <= NVSC_IDLE;
					end
				end
				NVSC_PULSE:
				begin
					// Hold the request pulse, then release and wait the grace window plus the store time
					if (tmr_r > 32'h0000_0001)
						tmr_r <= tmr_r - 32'h0000_0001;
					else
					begin
						hw_store_busy_n_oe <= 1'b0;
						tmr_r              <= 32'(GRACE_CYC + STORE_CYC);
						busy_seen_r        <= 1'b0;
						st_r               <= NVSC_BUSYW;
					end
				end
				NVSC_BUSYW:
				begin
					// Store may be skipped if nothing was written; busy stays high then RL20
					// First cycles ignored: the synchroniser still shows our own request pulse
					if (!busy_pin_n && (tmr_r + 32'd3 <= 32'(GRACE_CYC + STORE_CYC)))
						busy_seen_r <= 1'b1;
					if (tmr_r != 32'h0000_0000)
						tmr_r <= tmr_r - 32'h0000_0001;
					if ((busy_seen_r && busy_pin_n) || tmr_r == 32'h0000_0000)
					begin
						rsp_valid <= 1'b1;
						st_r      <= NVSC_IDLE;
					end
				end
				default:
					st_r <= NVSC_IDLE;
			endcase
		end
	end

	// Open-drain: only ever drives low
	assign hw_store_busy_n_o = 1'b0;

endmodule : nvsc_host
`default_nettype wire

/* test/nvsc_host_properties.sv */
// Checker for the host controller's memory pins, bound to nvsc_host.
// Assumes the command addresses come from nvsc_params.svh.
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_params.svh"

module nvsc_host_properties
(
	// Clock and reset
	input wire logic                 sys_clk,
	input wire logic                 reset,
	// Watched outputs
	input wire logic                 rsp_valid,
	input wire nvsc_pkg::nvsc_pins_t mem_pins,
	input wire logic                 dq_oe
);
	import nvsc_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic        e_n_d_r;     // Chip enable one edge ago
	logic [15:0] last_fall_r; // Write enable and address at the previous enable fall

	// Delayed enable, so that a fall is seen without sampled functions
	always_ff @(posedge sys_clk)
	begin
		e_n_d_r <= reset ? 1'b1 : mem_pins.e_n;
	end

	// Remember each access start; any access breaks a command chain
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			last_fall_r <= 16'h0000;
		else if (e_n_d_r && !mem_pins.e_n)
			last_fall_r <= {mem_pins.w_n, mem_pins.addr};
	end

	// Predecessor of a command address, zero for ordinary addresses
	function automatic logic [15:0] prev_of(input logic [14:0] a);
		case (a)
			`NVSC_SEQ_A1:    return {1'b1, `NVSC_SEQ_A0};
			`NVSC_SEQ_A2:    return {1'b1, `NVSC_SEQ_A1};
			`NVSC_SEQ_A3:    return {1'b1, `NVSC_SEQ_A2};
			`NVSC_SEQ_A4:    return {1'b1, `NVSC_SEQ_A3};
			`NVSC_CMD_ASDIS, `NVSC_CMD_ASEN,
			`NVSC_CMD_STORE, `NVSC_CMD_RECALL: return {1'b1, `NVSC_SEQ_A4};
			default:         return 16'h0000;
		endcase
	endfunction : prev_of

	// ----------------------------------------------------------------
	// Sequences and assertions
	// ----------------------------------------------------------------
	sequence rd_fall;
		e_n_d_r && !mem_pins.e_n && mem_pins.w_n;
	endsequence
	sequence wr_low;
		!mem_pins.e_n && !mem_pins.w_n;
	endsequence

	cmd_order_a: assert property (rd_fall ##0 (prev_of(mem_pins.addr) != 16'h0000)
		|-> last_fall_r == prev_of(mem_pins.addr))
		else $error("command read out of order");
	rd_w_high_a: assert property (!mem_pins.e_n && !mem_pins.g_n |-> mem_pins.w_n)
		else $error("write enable low during a read");
	wr_addr_hold_a: assert property (wr_low ##1 wr_low |-> $stable(mem_pins.addr))
		else $error("address moved during a write");
	no_contend_a: assert property (dq_oe |-> mem_pins.g_n)
		else $error("output enable low while host drives data");
	wr_pulse_a: assert property ($fell(mem_pins.w_n) |-> (!mem_pins.w_n)[*2])
		else $error("write pulse too short");
	reset_idle_a: assert property ($fell(reset) |-> mem_pins.e_n && mem_pins.w_n && !dq_oe)
		else $error("pins not idle after reset");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
endmodule : nvsc_host_properties

bind nvsc_host nvsc_host_properties u_props (.sys_clk(sys_clk), .reset(reset),
	.rsp_valid(rsp_valid), .mem_pins(mem_pins), .dq_oe(dq_oe));
`default_nettype wire

/* test/nvsc_nvram_model.sv */
// Behavioural model of the nonvolatile SRAM seen from its pins.
// Assumes the bench resolves the shared data lines and the pulled-up busy pin.
`timescale 1ns/1ps
`default_nettype none

module nvsc_nvram_model
#(
	parameter int SS_NS     = 600,
	parameter int STORE_NS  = 1000,
	parameter int RECALL_NS = 500,
	parameter int GRACE_NS  = 500
)
(
	// Host pins
	input  wire logic        e_n,
	input  wire logic        w_n,
	input  wire logic        g_n,
	input  wire logic [14:0] addr,
	input  wire logic [7:0]  dq_host,
	// Device drive and busy pin
	output logic [7:0]       dq_dev,
	output logic             dq_dev_oe,
	output logic             busy_pull,
	input  wire logic        busy_pin_n
);
	logic [7:0] sram [0:32767]; // Volatile array
	logic [7:0] nv   [0:32767]; // Shadow copy
	logic [7:0] last_r;         // Last driven byte, inverted when released
	logic       wrote, locked, float_r, wr_ok, as_en;
	int         step;
	wire        we = !e_n && !w_n;
	localparam logic [13:0] PRE [5] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};

	initial
	begin
		foreach (sram[i]) begin sram[i] = 8'h00; nv[i] = 8'h00; end
		{last_r, wrote, locked, float_r, wr_ok, busy_pull, step} = '0;
		as_en = 1'b1;
	end

	// Read drive; released lines show the inverse so stale data never matches
	assign dq_dev_oe = !e_n && !g_n && w_n && busy_pin_n && !locked && !float_r;
	assign dq_dev    = dq_dev_oe ? sram[addr] : ~last_r;
	always @(dq_dev_oe or addr) if (dq_dev_oe) last_r = sram[addr];

	// Store or recall after the command processing time, array locked
	task automatic run_op(input bit st);
		#SS_NS;
		locked = 1'b1;
		if (st) begin busy_pull = 1'b1; #STORE_NS; nv = sram; busy_pull = 1'b0; end
		else begin #RECALL_NS; sram = nv; end
		wrote  = 1'b0;
		locked = 1'b0;
	endtask : run_op

	// Command detector steps on enable-controlled reads, low 14 bits only
	always @(negedge e_n)
	begin
		if (!w_n || locked) step = 0;
		else if (step < 5) step = (addr[13:0] == PRE[step]) ? step + 1 : int'(addr[13:0] == PRE[0]);
		else
		begin
			step = 0;
			case (addr[13:0])
				14'h03f8: as_en = 1'b0;
				14'h07f0: as_en = 1'b1;
				14'h0fc0: begin float_r = 1'b1; fork run_op(1'b1); join_none end
				14'h0c63: begin float_r = 1'b1; fork run_op(1'b0); join_none end
				default:  step = int'(addr[13:0] == PRE[0]);
			endcase
		end
	end
	always @(posedge e_n) float_r = 1'b0;
	always @(negedge w_n) if (!e_n) step = 0;

	// Writes need a fresh enable fall and an idle busy pin
	always @(posedge we) wr_ok = busy_pin_n && !locked;
	always @(negedge we) if (wr_ok && !locked) begin sram[addr] = dq_host; wrote = 1'b1; end

	// Pin store request: grace period, then store only if written
	always @(negedge busy_pin_n)
	begin
		if (!busy_pull && !locked)
		begin
			#GRACE_NS;
			if (wrote)
			begin
				{locked, busy_pull} = 2'b11;
				#STORE_NS;
				nv = sram;
				{locked, busy_pull, wrote} = 3'b000;
			end
		end
	end
endmodule : nvsc_nvram_model
`default_nettype wire

/* test/nvsc_host_tb_top.sv */
// Self-checking bench: host controller against the memory model.
// Assumes shortened long waits; expectations come from a reference array.
`timescale 1ns/1ps
`default_nettype none

module nvsc_host_tb_top;
	import nvsc_pkg::*;
	logic        sys_clk   = 1'b0;
	logic        reset     = 1'b1;
	logic        req_valid = 1'b0;
	nvsc_req_t   req       = '0;
	logic        req_ready, rsp_valid, busy, dq_oe, pin_oe, pin_o, dev_oe, busy_pull;
	logic [7:0]  rsp_rdata, dq_o, dq_i, dq_dev;
	nvsc_pins_t  mem_pins;
	logic [31:0] seed = 32'd51544;
	logic [14:0] addr_q [$];
	int          ref_sram [int];
	int          ref_nv [int];
	bit          ref_wrote;
	int          num_errors = 0;
	int          tests_run  = 0;
	wire         pin_n = !(pin_oe && !pin_o) && !busy_pull; // Pulled up

	always #12.5 sys_clk = ~sys_clk;
	assign dq_i = dq_oe ? dq_o : dq_dev;

	// Both sides driving the data lines at once is a contention fault
	always @(posedge sys_clk)
		if (dq_oe && dev_oe) cmp8("data line drivers", 8'h00, 8'h01);

	nvsc_host #(.SS_US(1), .GRACE_US(1), .RECALL_US(1), .STORE_US(2)) dut (.sys_clk(sys_clk),
		.reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy), .mem_pins(mem_pins),
		.dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .hw_store_busy_n_o(pin_o),
		.hw_store_busy_n_oe(pin_oe), .hw_store_busy_n_i(pin_n));
	nvsc_nvram_model mem (.e_n(mem_pins.e_n), .w_n(mem_pins.w_n), .g_n(mem_pins.g_n),
		.addr(mem_pins.addr), .dq_host(dq_o), .dq_dev(dq_dev), .dq_dev_oe(dev_oe),
		.busy_pull(busy_pull), .busy_pin_n(pin_n));

	// ----------------------------------------------------------------
	// Reference model and helpers
	// ----------------------------------------------------------------
	function automatic void xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction : xs
	function automatic logic [7:0] ref_get(input logic [14:0] a);
		return ref_sram.exists(int'(a)) ? 8'(ref_sram[int'(a)]) : 8'h00;
	endfunction : ref_get
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin num_errors++; $display("ERROR %s expected %h got %h", what, exp, got); end
	endtask : cmp8

	// One request; waits bounded for take and answer, then updates the reference
	task automatic do_op(input nvsc_op_t op, input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (req_ready !== 1'b1 && n < 5000) begin @(negedge sys_clk); n++; end
		req_valid = 1'b1;
		req       = '{op: op, addr: a, wdata: d};
		@(negedge sys_clk);
		req_valid = 1'b0;
		cmp8("busy in flight", 8'h01, {7'h00, busy});
		while (rsp_valid !== 1'b1 && n < 5000) begin @(negedge sys_clk); n++; end
		if (n >= 5000) begin num_errors++; $display("ERROR response expected 1 got 0"); end
		cmp8("busy at answer", 8'h00, {7'h00, busy});
		case (op)
			NVSC_OP_WRITE:  begin ref_sram[int'(a)] = d; ref_wrote = 1'b1; end
			NVSC_OP_STORE:  begin ref_nv = ref_sram; ref_wrote = 1'b0; end
			NVSC_OP_RECALL: begin ref_sram = ref_nv; ref_wrote = 1'b0; end
			NVSC_OP_HWST:   if (ref_wrote) begin ref_nv = ref_sram; ref_wrote = 1'b0; end
			default:        ;
		endcase
	endtask : do_op
	task automatic check_rd(input logic [14:0] a);
		do_op(NVSC_OP_READ, a, 8'h00);
		cmp8("read data", ref_get(a), rsp_rdata);
	endtask : check_rd

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(negedge sys_clk);
		reset = 1'b0;
		// Random writes, each read back at once, then all again
		for (int i = 0; i < 12; i++)
		begin
			xs();
			do_op(NVSC_OP_WRITE, seed[22:8], seed[7:0]);
			addr_q.push_back(seed[22:8]);
			check_rd(seed[22:8]);
		end
		foreach (addr_q[i]) check_rd(addr_q[i]);
		$display("test random_rw done");
		// Data written at the command prefixes; autosave commands return the sixth read's data
		foreach (mem.PRE[i]) begin xs(); do_op(NVSC_OP_WRITE, {1'b0, mem.PRE[i]}, seed[7:0]); end
		do_op(NVSC_OP_WRITE, 15'h07f0, 8'h3c);
		do_op(NVSC_OP_WRITE, 15'h03f8, 8'hc3);
		do_op(NVSC_OP_AS_EN, 15'h0000, 8'h00);
		cmp8("enable read data", ref_get(15'h07f0), rsp_rdata);
		cmp8("autosave flag", 8'h01, {7'h00, mem.as_en});
		do_op(NVSC_OP_AS_DIS, 15'h0000, 8'h00);
		cmp8("disable read data", ref_get(15'h03f8), rsp_rdata);
		cmp8("autosave flag", 8'h00, {7'h00, mem.as_en});
		check_rd(addr_q[0]);
		$display("test autosave_cmds done");
		// Software store, overwrite, recall brings the stored byte back
		do_op(NVSC_OP_WRITE, 15'h1234, 8'h5a);
		do_op(NVSC_OP_STORE, 15'h0000, 8'h00);
		do_op(NVSC_OP_WRITE, 15'h1234, 8'ha5);
		check_rd(15'h1234);
		do_op(NVSC_OP_RECALL, 15'h0000, 8'h00);
		check_rd(15'h1234);
		$display("test soft_store_recall done");
		// Pin store after a write, then with no write since the recall
		do_op(NVSC_OP_WRITE, 15'h1234, 8'h77);
		do_op(NVSC_OP_HWST, 15'h0000, 8'h00);
		do_op(NVSC_OP_WRITE, 15'h1234, 8'h11);
		do_op(NVSC_OP_RECALL, 15'h0000, 8'h00);
		check_rd(15'h1234);
		do_op(NVSC_OP_HWST, 15'h0000, 8'h00);
		check_rd(15'h1234);
		$display("test pin_store done");
		print_verdict();
	end

	// Watchdog well beyond the expected run of just over a thousand cycles
	initial
	begin
		#500000;
		num_errors++;
		$display("ERROR watchdog expected done got timeout");
		print_verdict();
	end
endmodule : nvsc_host_tb_top
`default_nettype wire
